/* File: core/gpe_pkg.sv */
// Purpose: constants and types for the 8-bit port block
// Assumes: one port per instance, 32-bit AHB-Lite register slave
// Notes: offsets are byte addresses, registers take one aligned word
// Function
// - Each pin is configured, read and written without disturbing other pins.
// - Input register follows a pin only while its input path enable is set.
// - Output data reaches a pin only while its drive enable is set.
// - Pull enable switches the pull resistor for input pins; direction from pull select.
// - Drive enable set forces pull off, open-drain included.
// - Open-drain: drive low when data low, release when data high.
// - Set register writes ones only where write data is one.
// - Clear register writes zeros only where write data is one.
// - Toggle register inverts only where write data is one.
// - Two-bit drive code per pin; 0,2,1,3 order weakest to strongest.
// - Interrupts are edge only, per pin, one event per transition.
// - Polarity 0 latches falling edge, polarity 1 latches rising edge.
// - Line A raised only where line A enable is one; status still captured.
// - Line B raised only where line B enable is one; status still captured.
// - Status stays set until software clears it.
// - Writing one clears a status bit, zero leaves it.
// - Line held while status and its enable are both one.
// - Two-bit function field per pin at [2n+1:2n]; 00 port, others alternate.
// - Codes without an alternate function have no defined behaviour.
// - After reset pins are port-mode inputs with pulls disabled.
package gpe_pkg;
  localparam int PINS = 8;
  localparam logic [7:0] OFS_FUNC = 8'h00;
  localparam logic [7:0] OFS_OE = 8'h04;
  localparam logic [7:0] OFS_IE = 8'h08;
  localparam logic [7:0] OFS_IN = 8'h0C;
  localparam logic [7:0] OFS_OUT = 8'h10;
  localparam logic [7:0] OFS_SET = 8'h14;
  localparam logic [7:0] OFS_CLR = 8'h18;
  localparam logic [7:0] OFS_TGL = 8'h1C;
  localparam logic [7:0] OFS_ODE = 8'h20;
  localparam logic [7:0] OFS_PE = 8'h28;
  localparam logic [7:0] OFS_PS = 8'h2C;
  localparam logic [7:0] OFS_DS = 8'h34;
  localparam logic [7:0] OFS_POL = 8'h3C;
  localparam logic [7:0] OFS_IENA = 8'h40;
  localparam logic [7:0] OFS_IENB = 8'h44;
  localparam logic [7:0] OFS_INT = 8'h48;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_PS = 8'hFF;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] FUNC_PORT = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Pad-side signals for all pins of the port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
    logic [7:0] pull_up;
    logic [15:0] drive_code;
  } gpe_pad_s;

  // Alternate peripheral requests, one set per alternate function code (1 to 3)
  typedef struct packed {
    logic [7:0] out1;
    logic [7:0] oe1;
    logic [7:0] out2;
    logic [7:0] oe2;
    logic [7:0] out3;
    logic [7:0] oe3;
  } gpe_alt_s;

  // Whole block state
  typedef struct packed {
    logic [15:0] func;
    logic [7:0] oe;
    logic [7:0] ie;
    logic [7:0] inlev;
    logic [7:0] dout;
    logic [7:0] ode;
    logic [7:0] pe;
    logic [7:0] ps;
    logic [15:0] ds;
    logic [7:0] pol;
    logic [7:0] iena;
    logic [7:0] ienb;
    logic [7:0] stat;
    logic [7:0] pin_prev;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    gpe_pad_s pad;
    logic irq_a;
    logic irq_b;
  } gpe_state_s;
endpackage : gpe_pkg

/* File: core/gpe_port.sv */
// Purpose: 8-bit port with edge events, AHB-Lite register slave
// Assumes: pins synchronous to core_clk, single-word accesses
// Notes: all outputs except the tied-off hreadyout and hresp registered, one cycle after the effect
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
module gpe_port (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pull_en,
  output logic [7:0] pin_pull_up,
  output logic [15:0] pin_drive_code,
  input wire gpe_pkg::gpe_alt_s alt_req,
  output logic irq_a,
  output logic irq_b
);
  import gpe_pkg::*;

  gpe_state_s st_r;
  gpe_state_s st_nxt;
  logic [7:0] wd;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] hit;
  logic [7:0] clr_mask;
  logic [7:0] sel_out;
  logic [7:0] sel_oe;
  logic wr_now;
  logic [7:0] irq_a_src;

  // Pick the pad data for a pin from its function code
  function automatic logic [1:0] pad_pick(input logic [1:0] code, input logic dout,
                                          input logic oe, input gpe_alt_s a, input int n);
    logic [1:0] r;
    r = {oe, dout};
    unique case (code)
      2'h0: r = {oe, dout};
      2'h1: r = {a.oe1[n], a.out1[n]};
      2'h2: r = {a.oe2[n], a.out2[n]};
      2'h3: r = {a.oe3[n], a.out3[n]};
    endcase
    return r;
  endfunction : pad_pick

  assign wd = hwdata[7:0];
  assign wr_now = st_r.ph_valid & st_r.ph_write;

  // Edge finders on the raw pin input against its registered copy, input enable not applied
  assign rise = pin_in & ~st_r.pin_prev;
  assign fall = ~pin_in & st_r.pin_prev;
  assign hit = (st_r.pol & rise) | (~st_r.pol & fall);

  // Next state
  always_comb begin
    st_nxt = st_r;
    clr_mask = 8'h00;
    sel_out = 8'h00;
    sel_oe = 8'h00;
    st_nxt.pin_prev = pin_in;
    // Input register only follows enabled pins
    st_nxt.inlev = pin_in & st_r.ie;
    // Data phase write, one field per address; set, clear and toggle keep unmasked pins untouched
    if (wr_now) begin
      unique case (st_r.ph_addr)
        OFS_FUNC: st_nxt.func = hwdata[15:0];
        OFS_OE: st_nxt.oe = wd;
        OFS_IE: st_nxt.ie = wd;
        OFS_OUT: st_nxt.dout = wd;
        OFS_SET: st_nxt.dout = st_r.dout | wd;
        OFS_CLR: st_nxt.dout = st_r.dout & ~wd;
        OFS_TGL: st_nxt.dout = st_r.dout ^ wd;
        OFS_ODE: st_nxt.ode = wd;
        OFS_PE: st_nxt.pe = wd;
        OFS_PS: st_nxt.ps = wd;
        OFS_DS: st_nxt.ds = hwdata[15:0];
        OFS_POL: st_nxt.pol = wd;
        OFS_IENA: st_nxt.iena = wd;
        OFS_IENB: st_nxt.ienb = wd;
        OFS_INT: clr_mask = wd;
        default: clr_mask = 8'h00;
      endcase
    end
    // New events win over a clear in the same cycle
    st_nxt.stat = (st_r.stat & ~clr_mask) | hit;
    // Address phase capture
    st_nxt.ph_valid = hsel & hready & (htrans == HTRANS_NONSEQ);
    st_nxt.ph_write = hwrite;
    st_nxt.ph_addr = haddr[7:0];
    if (hsel & hready & (htrans == HTRANS_NONSEQ) & ~hwrite) begin
      unique case (haddr[7:0])
        OFS_FUNC: st_nxt.rdata = {16'h0000, st_r.func};
        OFS_OE: st_nxt.rdata = {24'h000000, st_r.oe};
        OFS_IE: st_nxt.rdata = {24'h000000, st_r.ie};
        OFS_IN: st_nxt.rdata = {24'h000000, st_r.inlev};
        OFS_OUT: st_nxt.rdata = {24'h000000, st_r.dout};
        OFS_ODE: st_nxt.rdata = {24'h000000, st_r.ode};
        OFS_PE: st_nxt.rdata = {24'h000000, st_r.pe};
        OFS_PS: st_nxt.rdata = {24'h000000, st_r.ps};
        OFS_DS: st_nxt.rdata = {16'h0000, st_r.ds};
        OFS_POL: st_nxt.rdata = {24'h000000, st_r.pol};
        OFS_IENA: st_nxt.rdata = {24'h000000, st_r.iena};
        OFS_IENB: st_nxt.rdata = {24'h000000, st_r.ienb};
        OFS_INT: st_nxt.rdata = {24'h000000, st_r.stat};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
    // Pad control, function mux first then open-drain and pull rules
    for (int n = 0; n < PINS; n++) begin
      {sel_oe[n], sel_out[n]} = pad_pick(st_r.func[2*n +: 2], st_r.dout[n],
                                         st_r.oe[n], alt_req, n);
    end
    // Open-drain pins only drive when data is low
    st_nxt.pad.oe = sel_oe & ~(st_r.ode & sel_out);
    st_nxt.pad.out = sel_out;
    // Pull only on non-driving pins; output enable kills it
    st_nxt.pad.pull_en = st_r.pe & ~sel_oe;
    st_nxt.pad.pull_up = st_r.ps;
    st_nxt.pad.drive_code = st_r.ds;
    // Level requests held while status and enable both set
    st_nxt.irq_a = |(st_nxt.stat & st_r.iena);
    st_nxt.irq_b = |(st_nxt.stat & st_r.ienb);
  end

  // Register the whole state; reset gives port-mode inputs, no pulls
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.ps <= RST_PS;
      st_r.pad.pull_up <= RST_PS;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign irq_a_src = st_r.stat & st_r.iena;
  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pin_out = st_r.pad.out;
  assign pin_oe = st_r.pad.oe;
  assign pin_pull_en = st_r.pad.pull_en;
  assign pin_pull_up = st_r.pad.pull_up;
  assign pin_drive_code = st_r.pad.drive_code;
  assign irq_a = st_r.irq_a;
  assign irq_b = st_r.irq_b;

  // Checks
  sequence set_write_s;
    clk_en && wr_now && st_r.ph_addr == OFS_SET;
  endsequence

  set_bits_a: assert property (@(posedge core_clk) disable iff (rst)
    set_write_s |=> (st_r.dout == ($past(st_r.dout) | $past(wd))))
    else $error("set write wrong");
  clr_bits_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && wr_now && st_r.ph_addr == OFS_CLR) |=>
      (st_r.dout == ($past(st_r.dout) & ~$past(wd))))
    else $error("clear write wrong");
  tgl_bits_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && wr_now && st_r.ph_addr == OFS_TGL) |=>
      (st_r.dout == ($past(st_r.dout) ^ $past(wd))))
    else $error("toggle write wrong");
  edge_latch_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && |hit) |=> ((st_r.stat & $past(hit)) == $past(hit)))
    else $error("edge not latched");
  stat_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !(wr_now && st_r.ph_addr == OFS_INT)) |=>
      ((st_r.stat & $past(st_r.stat)) == $past(st_r.stat)))
    else $error("status lost");
  // A status clear in the same cycle may legally withdraw the request
  line_a_level_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && |irq_a_src && !(wr_now && st_r.ph_addr == OFS_INT)) |=> irq_a)
    else $error("line A dropped");
  line_b_level_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && |(st_r.stat & st_r.ienb) && !(wr_now && st_r.ph_addr == OFS_INT)) |=> irq_b)
    else $error("line B dropped");
  // A masked pin never raises a line
  line_a_mask_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> (!irq_a || |(st_r.stat & $past(st_r.iena))))
    else $error("line A unmasked");
  line_b_mask_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> (!irq_b || |(st_r.stat & $past(st_r.ienb))))
    else $error("line B unmasked");
  // Zero bits of a status write keep their pending events
  w1c_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && wr_now && st_r.ph_addr == OFS_INT) |=>
      ((st_r.stat & $past(st_r.stat & ~wd)) == $past(st_r.stat & ~wd)))
    else $error("status zero write cleared");
  // Disabled input path keeps the input register at zero
  in_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en |=> ((st_r.inlev & ~$past(st_r.ie)) == 8'h00))
    else $error("input path leaked");
  // Port-mode pins without drive enable never drive
  drive_off_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && st_r.func == 16'h0000) |=> ((pin_oe & ~$past(st_r.oe)) == 8'h00))
    else $error("driver on while disabled");
  pull_off_a: assert property (@(posedge core_clk) disable iff (rst)
    (pin_pull_en & pin_oe) == 8'h00)
    else $error("pull while driving");
  od_high_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && (st_r.ode & st_r.dout) != 8'h00 && st_r.func == 16'h0000)
      |=> ((pin_oe & $past(st_r.ode & st_r.dout)) == 8'h00))
    else $error("open drain drove high");
endmodule : gpe_port

/* File: dv/gpe_pad_model.sv */
// Purpose: far-side pad model for the port
// Assumes: an outside driver is always present on released pads
// Notes: a driving pad reads back its own data
`timescale 1ns/1ns
module gpe_pad_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_lvl,
  output logic [7:0] pin_in
);
  // Pad wins while enabled, otherwise the outside level shows
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : gpe_pad_model

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for the port block
// Assumes: zero-wait AHB-Lite slave, pads seen through a pad model
// Notes: random config from a fixed seed, expectations from bench functions
`timescale 1ns/1ns
module tb_top;
  import gpe_pkg::*;
  logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, irq_a, irq_b, clk_en = 1;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, v, m, p, a, b;
  logic [1:0] htrans = '0;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pull_en, pin_pull_up, ext_lvl = '0;
  logic [15:0] pin_drive_code;
  logic [23:0] ex;
  logic [63:0] r64;
  gpe_alt_s alt_req = '0;
  int fail_count = 0, n_compared = 0, seed = 35129, k;
  logic [31:0] sh [11];
  logic [7:0] ofs [11] = '{OFS_FUNC, OFS_OE, OFS_IE, OFS_OUT, OFS_ODE, OFS_PE,
                           OFS_PS, OFS_DS, OFS_POL, OFS_IENA, OFS_IENB};

  always #5 core_clk = ~core_clk;

  gpe_port gpe_port_i (.core_clk, .rst, .clk_en, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready),
    .hresp(), .pin_in, .pin_out, .pin_oe, .pin_pull_en, .pin_pull_up,
    .pin_drive_code, .alt_req, .irq_a, .irq_b);
  gpe_pad_model gpe_pad_model_i (.pin_out, .pin_oe, .ext_lvl, .pin_in);

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Bounded wait for hready, a hang ends the run
  task wait_rdy;
    int n;
    n = 0;
    @(posedge core_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        print_verdict();
      end
      @(posedge core_clk);
    end
  endtask : wait_rdy

  // One single-word transfer, read data taken at the data-phase edge
  task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, ad};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task settle;
    @(posedge core_clk);
    #1;
  endtask : settle

  // Selected data, selected enable, and pad enable after open drain
  function automatic logic [23:0] pad_exp(input logic [15:0] f,
                                          input logic [7:0] d, oe, od);
    logic [7:0] so, se;
    for (int n = 0; n < PINS; n++) begin
      case (f[2*n +: 2])
        2'h0: {so[n], se[n]} = {d[n], oe[n]};
        2'h1: {so[n], se[n]} = {alt_req.out1[n], alt_req.oe1[n]};
        2'h2: {so[n], se[n]} = {alt_req.out2[n], alt_req.oe2[n]};
        default: {so[n], se[n]} = {alt_req.out3[n], alt_req.oe3[n]};
      endcase
    end
    return {so, se, se & ~(od & so)};
  endfunction : pad_exp

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    // Reset state of pads and registers
    chk("pull_up", pin_pull_up, RST_PS);
    chk("oe_pull", {pin_oe, pin_pull_en}, 16'h0);
    foreach (ofs[i]) begin
      xfer(1'b0, ofs[i], 32'h0);
      chk("reset", rd, (i == 6) ? {24'h0, RST_PS} : 32'h0);
    end
    // Random config, read back, then pad outputs against it
    repeat (6) begin
      r64 = {$random(seed), $random(seed)};
      alt_req <= r64[47:0];
      foreach (ofs[i]) begin
        sh[i] = $random(seed);
        xfer(1'b1, ofs[i], sh[i]);
        xfer(1'b0, ofs[i], 32'h0);
        chk("rw", rd, sh[i] & ((i == 0 || i == 7) ? 32'hFFFF : 32'hFF));
      end
      settle();
      ex = pad_exp(sh[0][15:0], sh[3][7:0], sh[1][7:0], sh[4][7:0]);
      chk("pin_out", pin_out, ex[23:16]);
      chk("pin_oe", pin_oe, ex[7:0]);
      chk("pull_en", pin_pull_en, sh[5][7:0] & ~ex[15:8]);
      chk("pull_up", pin_pull_up, sh[6][7:0]);
      chk("drive", pin_drive_code, sh[7][15:0]);
    end
    // Unmapped place ignores writes and reads zero
    xfer(1'b1, 8'h24, 32'hFFFFFFFF);
    xfer(1'b0, 8'h24, 32'h0);
    chk("unmapped", rd, 32'h0);
    // Set, clear and toggle touch only masked bits
    repeat (8) begin
      v = $random(seed) & 32'hFF;
      m = $random(seed);
      xfer(1'b1, OFS_OUT, v);
      xfer(1'b1, OFS_SET, m);
      xfer(1'b1, OFS_CLR, m >> 8);
      xfer(1'b1, OFS_TGL, m >> 16);
      v = ((v | (m & 32'hFF)) & ~(m >> 8 & 32'hFF)) ^ (m >> 16 & 32'hFF);
      xfer(1'b0, OFS_OUT, 32'h0);
      chk("out", rd, v);
    end
    // Pseudo open drain: low, then released onto the pull
    xfer(1'b1, OFS_FUNC, 32'h0);
    xfer(1'b1, OFS_ODE, 32'h0);
    xfer(1'b1, OFS_OUT, 32'h0);
    xfer(1'b1, OFS_PE, 32'h1);
    for (k = 1; k >= 0; k--) begin
      xfer(1'b1, OFS_OE, k);
      settle();
      chk("pseudo", {pin_oe[0], pin_pull_en[0]}, {k[0], ~k[0]});
    end
    // Input path gates the input register
    repeat (6) begin
      m = $random(seed);
      ext_lvl <= m[7:0];
      v = $random(seed) & 32'hFF;
      xfer(1'b1, OFS_IE, v);
      settle();
      xfer(1'b0, OFS_IN, 32'h0);
      chk("in", rd, v & {24'h0, ext_lvl});
    end
    // Edge events, line masks, sticky status, write-one clear
    repeat (8) begin
      p = $random(seed);
      m = $random(seed);
      a = $random(seed);
      b = $random(seed);
      xfer(1'b1, OFS_POL, p);
      xfer(1'b1, OFS_IENA, a);
      xfer(1'b1, OFS_IENB, b);
      ext_lvl <= ~p[7:0];
      repeat (3) @(posedge core_clk);
      xfer(1'b1, OFS_INT, 32'hFF);
      ext_lvl <= ~p[7:0] ^ m[7:0];
      repeat (3) @(posedge core_clk);
      #1;
      chk("irq_a", irq_a, |(m[7:0] & a[7:0]));
      chk("irq_b", irq_b, |(m[7:0] & b[7:0]));
      ext_lvl <= ~p[7:0];
      repeat (3) @(posedge core_clk);
      xfer(1'b0, OFS_INT, 32'h0);
      chk("status", rd, m & 32'hFF);
      xfer(1'b1, OFS_INT, m >> 8);
      xfer(1'b0, OFS_INT, 32'h0);
      chk("w1c", rd, m & ~(m >> 8) & 32'hFF);
      xfer(1'b1, OFS_INT, 32'hFF);
      settle();
      chk("irq_off", {irq_a, irq_b}, 2'h0);
    end
    // Frozen block misses edges that come and go while the enable is low
    clk_en <= 1'b0;
    ext_lvl <= p[7:0];
    repeat (3) @(posedge core_clk);
    ext_lvl <= ~p[7:0];
    @(posedge core_clk);
    clk_en <= 1'b1;
    xfer(1'b0, OFS_INT, 32'h0);
    chk("frozen", rd, 32'h0);
    print_verdict();
  end
endmodule : tb_top
